/* File: lem_monitor.sv */
// The implementer's own choices: the address map and the Avalon-MM register port.
module lem_monitor
  import lem_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire lem_err_t            err,
  output lem_evt_t                 evt,
  output logic [15:0]              seq_num,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  output logic [DATA_W-1:0]        avs_readdata,
  output logic                     avs_waitrequest
);

  function automatic logic [63:0] bump(input logic [63:0] v, input logic clr, input logic inc);
    bump = (clr ? 64'h0 : v) + {63'h0, inc};
  endfunction

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Oversized writes saturate, so a huge value never wraps into a tiny window
  function automatic logic [15:0] sat16(input logic [31:0] v);
    sat16 = (v[31:16] != 16'h0) ? '1 : v[15:0];
  endfunction

  logic        tick;
  logic        sec_tick;
  logic        ack;
  logic        wr_go;
  logic        clr;
  logic        en;
  logic [15:0] fe_win;
  logic [31:0] fe_thr;
  logic [31:0] fp_win;
  logic [31:0] fp_thr;
  logic [63:0] sp_win;
  logic [63:0] sp_thr;
  logic [15:0] ss_win;
  logic [15:0] ss_thr;
  logic [15:0] ts_now;
  logic [15:0] fe_ts;
  logic [15:0] fp_ts;
  logic [15:0] sp_ts;
  logic [15:0] ss_ts;
  logic [15:0] fe_tmr;
  logic [31:0] fe_cnt;
  logic [63:0] fe_tot;
  logic [31:0] fe_evn;
  logic [31:0] fp_frm;
  logic [31:0] fp_cnt;
  logic [63:0] fp_tot;
  logic [31:0] fp_evn;
  logic [63:0] sp_sym;
  logic [63:0] sp_cnt;
  logic [63:0] sp_tot;
  logic [31:0] sp_evn;
  logic [15:0] ss_tmr;
  logic [15:0] ss_cnt;
  logic [31:0] ss_tot;
  logic [31:0] ss_evn;
  logic        err_sec;
  logic        es_hit;
  logic        fe_in;
  logic        fr_in;
  logic        sy_in;
  logic        se_in;
  logic        fe_end;
  logic        fp_end;
  logic        sp_end;
  logic        ss_end;
  logic [31:0] next_fe_cnt;
  logic [31:0] next_fp_cnt;
  logic [63:0] next_sp_cnt;
  logic [15:0] next_ss_cnt;
  lem_evt_t    next_evt;

  lem_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick     (tick),
    .sec_tick (sec_tick)
  );

  // One wait state on every access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_go = avs_write && ack;
  assign clr   = wr_go && (avs_address == REG_CTRL) && avs_writedata[CTRL_CLR_BIT];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      en     <= CTRL_EN_RST;
      fe_win <= FE_WIN_RST;
      fe_thr <= FE_THR_RST;
      fp_win <= FP_WIN_RST;
      fp_thr <= FP_THR_RST;
      sp_win <= SP_WIN_RST;
      sp_thr <= SP_THR_RST;
      ss_win <= SS_WIN_RST;
      ss_thr <= SS_THR_RST;
    end else if (wr_go) begin
      unique case (avs_address)
        REG_CTRL:      en <= avs_writedata[CTRL_EN_BIT];
        REG_FE_WIN:    fe_win <= clamp16(sat16(avs_writedata), FE_WIN_MIN, FE_WIN_MAX);
        REG_FE_THR:    fe_thr <= avs_writedata;
        REG_FP_WIN:    fp_win <= avs_writedata;
        REG_FP_THR:    fp_thr <= avs_writedata;
        REG_SP_WIN_LO: sp_win[31:0] <= avs_writedata;
        REG_SP_WIN_HI: sp_win[63:32] <= avs_writedata;
        REG_SP_THR_LO: sp_thr[31:0] <= avs_writedata;
        REG_SP_THR_HI: sp_thr[63:32] <= avs_writedata;
        REG_SS_WIN:    ss_win <= clamp16(sat16(avs_writedata), SS_WIN_MIN, SS_WIN_MAX);
        REG_SS_THR:    ss_thr <= sat16(avs_writedata);
        default:       ;
      endcase
    end
  end

  // Register read mux; unmapped words read zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      unique case (avs_address)
        REG_CTRL:      avs_readdata <= {31'h0, en};
        REG_FE_WIN:    avs_readdata <= {16'h0, fe_win};
        REG_FE_THR:    avs_readdata <= fe_thr;
        REG_FP_WIN:    avs_readdata <= fp_win;
        REG_FP_THR:    avs_readdata <= fp_thr;
        REG_SP_WIN_LO: avs_readdata <= sp_win[31:0];
        REG_SP_WIN_HI: avs_readdata <= sp_win[63:32];
        REG_SP_THR_LO: avs_readdata <= sp_thr[31:0];
        REG_SP_THR_HI: avs_readdata <= sp_thr[63:32];
        REG_SS_WIN:    avs_readdata <= {16'h0, ss_win};
        REG_SS_THR:    avs_readdata <= {16'h0, ss_thr};
        REG_SEQ:       avs_readdata <= {16'h0, seq_num};
        REG_FE_TS:     avs_readdata <= {16'h0, fe_ts};
        REG_FP_TS:     avs_readdata <= {16'h0, fp_ts};
        REG_SP_TS:     avs_readdata <= {16'h0, sp_ts};
        REG_SS_TS:     avs_readdata <= {16'h0, ss_ts};
        REG_FE_CNT:    avs_readdata <= fe_cnt;
        REG_FE_TOT_LO: avs_readdata <= fe_tot[31:0];
        REG_FE_TOT_HI: avs_readdata <= fe_tot[63:32];
        REG_FE_EVN:    avs_readdata <= fe_evn;
        REG_FP_CNT:    avs_readdata <= fp_cnt;
        REG_FP_TOT_LO: avs_readdata <= fp_tot[31:0];
        REG_FP_TOT_HI: avs_readdata <= fp_tot[63:32];
        REG_FP_EVN:    avs_readdata <= fp_evn;
        REG_SP_CNT_LO: avs_readdata <= sp_cnt[31:0];
        REG_SP_CNT_HI: avs_readdata <= sp_cnt[63:32];
        REG_SP_TOT_LO: avs_readdata <= sp_tot[31:0];
        REG_SP_TOT_HI: avs_readdata <= sp_tot[63:32];
        REG_SP_EVN:    avs_readdata <= sp_evn;
        REG_SS_CNT:    avs_readdata <= {16'h0, ss_cnt};
        REG_SS_TOT:    avs_readdata <= ss_tot;
        REG_SS_EVN:    avs_readdata <= ss_evn;
        default:       avs_readdata <= '0;
      endcase
    end
  end

  // Indications are dropped while monitoring is disabled
  assign fe_in = en && err.frame_err;
  assign fr_in = en && err.frame_done;
  assign sy_in = en && err.sym_done;
  assign se_in = en && err.sym_err;

  // Window ends; a window of zero behaves as a window of one
  assign fe_end = tick && (({1'b0, fe_tmr} + 17'h1) >= {1'b0, fe_win});
  assign fp_end = fr_in && (({1'b0, fp_frm} + 33'h1) >= {1'b0, fp_win});
  assign sp_end = sy_in && (({1'b0, sp_sym} + 65'h1) >= {1'b0, sp_win});
  assign ss_end = tick && (({1'b0, ss_tmr} + 17'h1) >= {1'b0, ss_win});
  assign es_hit = sec_tick && (err_sec || fe_in);

  // The error in a window's last cycle still counts toward that window
  assign next_fe_cnt = 32'(bump({32'h0, fe_cnt}, clr, fe_in));
  assign next_fp_cnt = 32'(bump({32'h0, fp_cnt}, clr, fe_in));
  assign next_sp_cnt = bump(sp_cnt, clr, se_in);
  assign next_ss_cnt = 16'(bump({48'h0, ss_cnt}, clr, es_hit));

  always_comb begin
    next_evt.fe = fe_end && (next_fe_cnt >= fe_thr);
    next_evt.fp = fp_end && (next_fp_cnt >= fp_thr);
    next_evt.sp = sp_end && (next_sp_cnt >= sp_thr);
    next_evt.ss = ss_end && (next_ss_cnt >= ss_thr);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fe_tmr <= '0;
      ss_tmr <= '0;
    end else if (tick) begin
      fe_tmr <= fe_end ? '0 : fe_tmr + 16'h1;
      ss_tmr <= ss_end ? '0 : ss_tmr + 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fp_frm <= '0;
    end else if (fr_in) begin
      fp_frm <= fp_end ? '0 : fp_frm + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sp_sym <= '0;
    end else if (sy_in) begin
      sp_sym <= sp_end ? '0 : sp_sym + 64'h1;
    end
  end

  // An errored frame on the second boundary is charged to the closing second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_sec <= 1'b0;
    end else begin
      err_sec <= sec_tick ? 1'b0 : (err_sec || fe_in);
    end
  end

  // Window counts restart after the compare
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fe_cnt <= '0;
      fp_cnt <= '0;
      sp_cnt <= '0;
      ss_cnt <= '0;
    end else begin
      fe_cnt <= fe_end ? '0 : next_fe_cnt;
      fp_cnt <= fp_end ? '0 : next_fp_cnt;
      sp_cnt <= sp_end ? '0 : next_sp_cnt;
      ss_cnt <= ss_end ? '0 : next_ss_cnt;
    end
  end

  // Totals; an increment in the clearing cycle survives the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fe_tot <= '0;
      fp_tot <= '0;
      sp_tot <= '0;
      ss_tot <= '0;
    end else begin
      fe_tot <= bump(fe_tot, clr, fe_in);
      fp_tot <= bump(fp_tot, clr, fe_in);
      sp_tot <= bump(sp_tot, clr, se_in);
      ss_tot <= 32'(bump({32'h0, ss_tot}, clr, es_hit));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fe_evn <= '0;
      fp_evn <= '0;
      sp_evn <= '0;
      ss_evn <= '0;
    end else begin
      fe_evn <= 32'(bump({32'h0, fe_evn}, clr, next_evt.fe));
      fp_evn <= 32'(bump({32'h0, fp_evn}, clr, next_evt.fp));
      sp_evn <= 32'(bump({32'h0, sp_evn}, clr, next_evt.sp));
      ss_evn <= 32'(bump({32'h0, ss_evn}, clr, next_evt.ss));
    end
  end

  // Free-running time base, not cleared so timestamps stay comparable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ts_now <= '0;
    end else if (tick) begin
      ts_now <= ts_now + 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fe_ts <= '0;
      fp_ts <= '0;
      sp_ts <= '0;
      ss_ts <= '0;
    end else begin
      fe_ts <= next_evt.fe ? ts_now : (clr ? '0 : fe_ts);
      fp_ts <= next_evt.fp ? ts_now : (clr ? '0 : fp_ts);
      sp_ts <= next_evt.sp ? ts_now : (clr ? '0 : sp_ts);
      ss_ts <= next_evt.ss ? ts_now : (clr ? '0 : ss_ts);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_num <= '0;
      evt     <= '0;
    end else begin
      seq_num <= (clr ? 16'h0 : seq_num) + 16'(next_evt.fe) + 16'(next_evt.fp)
                 + 16'(next_evt.sp) + 16'(next_evt.ss);
      evt     <= next_evt;
    end
  end

endmodule

/* File: lem_pkg.sv */
package lem_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_PERIOD_NS  = 100_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_SEC   = 10;

  // Avalon-MM register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Byte offsets of the register words
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_FE_WIN    = 8'h04;
  localparam logic [7:0] REG_FE_THR    = 8'h08;
  localparam logic [7:0] REG_FP_WIN    = 8'h0C;
  localparam logic [7:0] REG_FP_THR    = 8'h10;
  localparam logic [7:0] REG_SP_WIN_LO = 8'h14;
  localparam logic [7:0] REG_SP_WIN_HI = 8'h18;
  localparam logic [7:0] REG_SP_THR_LO = 8'h1C;
  localparam logic [7:0] REG_SP_THR_HI = 8'h20;
  localparam logic [7:0] REG_SS_WIN    = 8'h24;
  localparam logic [7:0] REG_SS_THR    = 8'h28;
  localparam logic [7:0] REG_SEQ       = 8'h2C;
  localparam logic [7:0] REG_FE_TS     = 8'h30;
  localparam logic [7:0] REG_FP_TS     = 8'h34;
  localparam logic [7:0] REG_SP_TS     = 8'h38;
  localparam logic [7:0] REG_SS_TS     = 8'h3C;
  localparam logic [7:0] REG_FE_CNT    = 8'h40;
  localparam logic [7:0] REG_FE_TOT_LO = 8'h44;
  localparam logic [7:0] REG_FE_TOT_HI = 8'h48;
  localparam logic [7:0] REG_FE_EVN    = 8'h4C;
  localparam logic [7:0] REG_FP_CNT    = 8'h50;
  localparam logic [7:0] REG_FP_TOT_LO = 8'h54;
  localparam logic [7:0] REG_FP_TOT_HI = 8'h58;
  localparam logic [7:0] REG_FP_EVN    = 8'h5C;
  localparam logic [7:0] REG_SP_CNT_LO = 8'h60;
  localparam logic [7:0] REG_SP_CNT_HI = 8'h64;
  localparam logic [7:0] REG_SP_TOT_LO = 8'h68;
  localparam logic [7:0] REG_SP_TOT_HI = 8'h6C;
  localparam logic [7:0] REG_SP_EVN    = 8'h70;
  localparam logic [7:0] REG_SS_CNT    = 8'h74;
  localparam logic [7:0] REG_SS_TOT    = 8'h78;
  localparam logic [7:0] REG_SS_EVN    = 8'h7C;

  // Control word fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_CLR_BIT = 1;

  // Reset values and limits; FE and SS windows in 100 ms ticks, FP window in frames, SP window in symbols
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam logic [15:0] FE_WIN_RST  = 16'h000A;
  localparam logic [15:0] FE_WIN_MIN  = 16'h000A;
  localparam logic [15:0] FE_WIN_MAX  = 16'h0258;
  localparam logic [31:0] FE_THR_RST  = 32'h0000_0001;
  localparam logic [31:0] FP_WIN_RST  = 32'h000F_4240;
  localparam logic [31:0] FP_THR_RST  = 32'h0000_0001;
  localparam logic [63:0] SP_WIN_RST  = 64'h0000_0000_0773_5940;
  localparam logic [63:0] SP_THR_RST  = 64'h0000_0000_0000_0001;
  localparam logic [15:0] SS_WIN_RST  = 16'h0258;
  localparam logic [15:0] SS_WIN_MIN  = 16'h0064;
  localparam logic [15:0] SS_WIN_MAX  = 16'h2328;
  localparam logic [15:0] SS_THR_RST  = 16'h0001;

  // Error indications from the port MAC and PHY, one cycle each
  typedef struct packed {
    logic frame_done;
    logic frame_err;
    logic sym_done;
    logic sym_err;
  } lem_err_t;

  // Generated link events, one-cycle pulses
  typedef struct packed {
    logic fe;
    logic fp;
    logic sp;
    logic ss;
  } lem_evt_t;

endpackage

/* File: lem_tick.sv */
module lem_tick
  import lem_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      tick,
  output logic      sec_tick
);

  logic [31:0] div;
  logic [7:0]  sub;
  logic        div_end;

  assign div_end = (div == 32'(TICK_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div <= '0;
    end else begin
      div <= div_end ? '0 : div + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sub <= '0;
    end else if (div_end) begin
      sub <= (sub == 8'(TICKS_PER_SEC - 1)) ? '0 : sub + 8'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick     <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      tick     <= div_end;
      sec_tick <= div_end && (sub == 8'(TICKS_PER_SEC - 1));
    end
  end

endmodule

/* File: lem_monitor_properties.sv */
module lem_monitor_properties
  import lem_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire lem_err_t          err,
  input wire lem_evt_t          evt,
  input wire logic [15:0]       seq_num,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic ctrl_wr;
  logic ctrl_clr;
  assign req = avs_read | avs_write;
  assign ctrl_wr = avs_write & ~avs_waitrequest & (avs_address == REG_CTRL);
  // Besides an event and reset release, a completed clear write is the only other lawful cause of a sequence change
  assign ctrl_clr = ctrl_wr & avs_writedata[CTRL_CLR_BIT];

  chk_seq_count: assert property (|evt |->
    seq_num == 16'(($past(ctrl_clr) ? '0 : $past(seq_num)) + $countones(evt)))
    else $error("Sequence number does not step with the events");
  chk_seq_cause: assert property ($changed(seq_num) |-> |evt || $past(ctrl_clr) || !$past(rst_n))
    else $error("Sequence number moved without an event");
  chk_fe_gap: assert property (evt.fe |=> !evt.fe [*8])
    else $error("Frame error events closer than a window");
  chk_ss_gap: assert property (evt.ss |=> !evt.ss [*8])
    else $error("Summary events closer than a window");
  chk_clr_reads0: assert property (avs_read && !avs_waitrequest && avs_address == REG_CTRL |->
    !avs_readdata[CTRL_CLR_BIT])
    else $error("Clear bit does not read back as zero");
  chk_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("New request answered without a wait state");
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("Request waited more than one cycle");
  chk_idle_ready: assert property (!req |-> !avs_waitrequest)
    else $error("Wait raised with no request");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[7] |-> avs_readdata == '0)
    else $error("Unmapped read returned data");
  chk_rdata_hold: assert property (!$past(avs_read) && $past(rst_n) |-> $stable(avs_readdata))
    else $error("Read data changed without a read");
  chk_rst_quiet: assert property ($rose(rst_n) |-> evt == '0 && seq_num == '0)
    else $error("Outputs not quiet after reset");
endmodule

bind lem_monitor lem_monitor_properties #(
  .TICK_CYCLES(TICK_CYCLES)
) i_lem_monitor_properties (
  .mclk(mclk), .rst_n(rst_n), .err(err), .evt(evt), .seq_num(seq_num),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

/* File: lem_phy_model.sv */
module lem_phy_model
  import lem_pkg::*;
(
  input wire logic mclk,
  output lem_err_t err
);
  timeunit 1ns;
  timeprecision 1ns;
  initial err = '0;
  // Frames need more than one cycle on the wire, so a gap follows each pulse
  task automatic frames(input int n, input int ne);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      err <= '{1'b1, (i < ne), 1'b0, 1'b0};
      @(posedge mclk);
      err <= '0;
    end
  endtask
  task automatic syms(input int n, input int ne);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      err <= '{1'b0, 1'b0, 1'b1, (i < ne)};
    end
    @(posedge mclk);
    err <= '0;
  endtask
endmodule

/* File: lem_monitor_test.sv */
module lem_monitor_test
  import lem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  lem_err_t    err;
  lem_evt_t    evt;
  logic [15:0] seq_num;
  logic [7:0]  addr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] rq;
  logic [31:0] t0;
  logic        wreq;
  int          err_total = 0;
  int          comparisons = 0;
  int          nfe;
  int          n_ev [4] = '{0, 0, 0, 0};

  lem_phy_model i_lem_phy_model (.mclk(mclk), .err(err));
  // Short tick: a second is 200 cycles
  lem_monitor #(.TICK_CYCLES(20)) i_lem_monitor (
    .mclk(mclk), .rst_n(rst_n), .err(err), .evt(evt), .seq_num(seq_num),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wreq)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    for (int k = 0; k < 4; k++) begin
      if (evt[3 - k] === 1'b1) n_ev[k] <= n_ev[k] + 1;
    end
  end

  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do @(posedge mclk); while (wreq !== 1'b0);
    rq = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    check(rq, e);
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    bus(1'b1, a, d);
    rchk(a, e);
  endtask
  task automatic wait_ev(input int k, input int lim);
    int n0;
    n0 = n_ev[k];
    for (int i = 0; i < lim && n_ev[k] == n0; i++) @(posedge mclk);
  endtask

  task automatic s_defaults();
    rchk(REG_CTRL, 32'h1);
    rchk(REG_FE_WIN, 32'hA);
    rchk(REG_FE_THR, 32'h1);
    rchk(REG_FP_WIN, 32'h000F_4240);
    rchk(REG_FP_THR, 32'h1);
    rchk(REG_SP_WIN_LO, 32'h0773_5940);
    rchk(REG_SP_THR_LO, 32'h1);
    rchk(REG_SS_WIN, 32'h258);
    rchk(REG_SS_THR, 32'h1);
    rchk(REG_SEQ, 32'h0);
    rchk(8'h80, 32'h0);
  endtask
  task automatic s_clamp();
    wchk(REG_FE_WIN, 32'h5, 32'hA);
    wchk(REG_FE_WIN, 32'h3E8, 32'h258);
    wchk(REG_FE_WIN, 32'h0001_0000, 32'h258);
    wchk(REG_FE_WIN, 32'hA, 32'hA);
    wchk(REG_SS_WIN, 32'h1, 32'h64);
    wchk(REG_SS_THR, 32'h0001_0000, 32'hFFFF);
    wchk(REG_SS_THR, 32'h1, 32'h1);
    wchk(8'h84, 32'h5, 32'h0);
  endtask
  task automatic s_period();
    wchk(REG_FP_WIN, 32'h4, 32'h4);
    wchk(REG_FP_THR, 32'h2, 32'h2);
    i_lem_phy_model.frames(2, 1);
    rchk(REG_FP_CNT, 32'h1);
    i_lem_phy_model.frames(2, 1);
    wait_ev(1, 8);
    check(n_ev[1], 1);
    rchk(REG_FP_EVN, 32'h1);
    rchk(REG_FP_CNT, 32'h0);
    i_lem_phy_model.frames(4, 1);
    wait_ev(1, 8);
    check(n_ev[1], 1);
    rchk(REG_FP_TOT_LO, 32'h3);
  endtask
  task automatic s_symbol();
    wchk(REG_SP_WIN_LO, 32'h8, 32'h8);
    wchk(REG_SP_THR_LO, 32'h3, 32'h3);
    i_lem_phy_model.syms(5, 2);
    rchk(REG_SP_CNT_LO, 32'h2);
    i_lem_phy_model.syms(3, 1);
    wait_ev(2, 8);
    check(n_ev[2], 1);
    rchk(REG_SP_EVN, 32'h1);
    rchk(REG_SP_TOT_LO, 32'h3);
    rchk(REG_SP_CNT_LO, 32'h0);
  endtask
  // Threshold zero fires at each window end, which lines the bench up with the windows
  task automatic s_frame_err();
    wchk(REG_FE_THR, 32'h0, 32'h0);
    wait_ev(0, 250);
    bus(1'b0, REG_FE_TS, '0);
    t0 = rq;
    wchk(REG_FE_THR, 32'h3, 32'h3);
    i_lem_phy_model.frames(2, 2);
    rchk(REG_FE_CNT, 32'h2);
    nfe = n_ev[0];
    repeat (200) @(posedge mclk);
    check(n_ev[0], nfe);
    rchk(REG_FE_CNT, 32'h0);
    i_lem_phy_model.frames(3, 3);
    wait_ev(0, 250);
    check(n_ev[0], nfe + 1);
    rchk(REG_FE_EVN, n_ev[0]);
    rchk(REG_FE_TOT_LO, 32'h8);
    rchk(REG_FE_TOT_HI, 32'h0);
    rchk(REG_FE_TS, t0 + 32'd20);
    wchk(REG_CTRL, 32'h0, 32'h0);
    i_lem_phy_model.frames(2, 2);
    rchk(REG_FE_TOT_LO, 32'h8);
    bus(1'b1, REG_CTRL, 32'h1);
  endtask
  task automatic s_summary();
    wait_ev(3, 2200);
    check(n_ev[3], 1);
    rchk(REG_SS_EVN, n_ev[3]);
    rchk(REG_SS_CNT, 32'h0);
    bus(1'b0, REG_SS_TOT, '0);
    t0 = rq;
    i_lem_phy_model.frames(1, 1);
    repeat (200) @(posedge mclk);
    rchk(REG_SS_CNT, 32'h1);
    i_lem_phy_model.frames(2, 2);
    repeat (200) @(posedge mclk);
    rchk(REG_SS_CNT, 32'h2);
    rchk(REG_SS_TOT, t0 + 32'd2);
  endtask
  task automatic s_clear();
    nfe = n_ev[0] + n_ev[1] + n_ev[2] + n_ev[3];
    rchk(REG_SEQ, nfe);
    check(seq_num, nfe);
    bus(1'b1, REG_CTRL, 32'h3);
    rchk(REG_CTRL, 32'h1);
    rchk(REG_SEQ, 32'h0);
    rchk(REG_FE_TOT_LO, 32'h0);
    rchk(REG_FE_EVN, 32'h0);
    rchk(REG_SS_TOT, 32'h0);
    rchk(REG_FE_TS, 32'h0);
    check(seq_num, 32'h0);
  endtask

  initial begin
    repeat (12000) @(posedge mclk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    s_defaults();
    s_clamp();
    s_period();
    s_symbol();
    s_frame_err();
    s_summary();
    s_clear();
    print_verdict();
  end
endmodule
